// *** verilog/reor_pkg.sv ***
// Package: register map, field positions, reset values and the serial port state codes
package reor_pkg;

    // ==========================================================
    // Register offsets on the serial register port
    localparam logic [7:0] OFS_OVERRIDE_A  = 8'hA0;
    localparam logic [7:0] OFS_OVERRIDE_B  = 8'hA1;
    localparam logic [7:0] OFS_FAULT_MASK  = 8'hA2;

    // ==========================================================
    // Values held before the factory settings are loaded, and the read value of unmapped offsets
    localparam logic [7:0] RST_OVERRIDE_A  = 8'h00;
    localparam logic [7:0] RST_OVERRIDE_B  = 8'h00;
    localparam logic [7:0] RST_FAULT_MASK  = 8'h00;
    localparam logic [7:0] RST_READ_DATA   = 8'h00;

    // ==========================================================
    // Rail numbering used on every rail vector of the block
    localparam int NUM_RAILS        = 12;
    localparam int NUM_MASKED_RAILS = 8;
    localparam int NUM_GPO          = 4;
    localparam int RAIL_STEP_DOWN1  = 0;   // Step-down rails 1..6 sit at 0..5
    localparam int RAIL_SWITCH_A1   = 6;
    localparam int RAIL_LDO_TWO     = 7;
    localparam int RAIL_LDO_THREE   = 8;
    localparam int RAIL_SWITCH_B1   = 9;
    localparam int RAIL_SWITCH_B2   = 10;
    localparam int RAIL_TERM_LDO    = 11;

    // ==========================================================
    // Field positions in the second override register
    localparam int OVB_FORCE_LSB    = 0;   // Force bits for rails 8..11
    localparam int OVB_FORCE_W      = 4;
    localparam int OVB_LEVEL_LSB    = 4;   // Levels of outputs 1..4
    localparam int GPO_OPEN_DRAIN_ONLY = 3; // Output 4, index 3

    // ==========================================================
    // Serial target addressing and counts
    localparam logic [6:0] TARGET_ADDR_DEFAULT = 7'h5E; // Arbitrary value
    localparam logic [3:0] BITS_PER_BYTE       = 4'h8;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0000,
        ST_ADDR   = 4'b0001,
        ST_AACK   = 4'b0010,
        ST_REG    = 4'b0011,
        ST_RACKR  = 4'b0100,
        ST_WDATA  = 4'b0101,
        ST_WACK   = 4'b0110,
        ST_RDATA  = 4'b0111,
        ST_MACK   = 4'b1000
    } reor_state_type;

endpackage

// *** verilog/reor_rail_gate.sv ***
// Module: per-rail enable gating and fault shutdown request
`timescale 1ns/1ps

module reor_rail_gate
(
    input  wire logic                               clk,
    input  wire logic                               rst_n,
    input  wire logic [reor_pkg::NUM_RAILS-1:0]     force_on,
    input  wire logic [reor_pkg::NUM_RAILS-1:0]     rail_kill_n,
    input  wire logic [reor_pkg::NUM_RAILS-1:0]     seq_request,
    input  wire logic [reor_pkg::NUM_MASKED_RAILS-1:0] fault_ignore,
    input  wire logic [reor_pkg::NUM_MASKED_RAILS-1:0] rail_fault,
    output logic      [reor_pkg::NUM_RAILS-1:0]     rail_enable,
    output logic                                    shutdown_req
);

    // ==========================================================
    // Rail enables
    // One flop per rail keeps the enable glitch-free toward the regulator
    genvar i;
    generate
        for (i = 0; i < reor_pkg::NUM_RAILS; i = i + 1)
        begin : g_rail
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    rail_enable[i] <= 1'b0;
                else // Kill wins over force; force ORs with pin request
                    rail_enable[i] <= rail_kill_n[i] & (force_on[i] | seq_request[i]);
            end
        end
    endgenerate

    // ==========================================================
    // Shutdown request from any fault that is not ignored
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            shutdown_req <= 1'b0;
        else
            shutdown_req <= |(rail_fault & ~fault_ignore);
    end

endmodule // reor_rail_gate

// *** verilog/reor_top.sv ***
// Module: rail enable override, output level and fault mask registers behind a serial target
// Notes on behaviour
// - The first override register at 0xA0 holds force bits for ldo two, switch A1, step-down 6..1.
// - With its force bit clear a rail follows only its control pin or power-good sequencing request.
// - With its force bit set a rail is on whatever its request, unless its kill bit is zero.
// - The register at 0xA1 holds force bits for termination ldo, switch B2, switch B1, ldo three.
// - Bits 7..4 of 0xA1 set outputs 4..1, only where the pin is configured as an output.
// - A level of zero drives the configured output low; a level of one drives a push-pull output high and leaves an open-drain one floating.
// - Output 4 is open-drain only; outputs 3..1 may be open-drain or push-pull.
// - Level bits of outputs 4 and 3 may be unused and then have no effect.
// - The fault mask register at 0xA2 covers ldo two, switch A1, step-down 6..1, all read/write.
// - Override, level and mask registers take their values from the factory settings.
// - A kill bit of zero turns its rail off regardless of pin state and force bit.
// - A rail's fault causes shutdown only while its mask bit is zero.
`timescale 1ns/1ps

module reor_top
#(
    parameter logic [6:0] TARGET_ADDR = reor_pkg::TARGET_ADDR_DEFAULT
)
(
    input  wire logic                                  clk,
    input  wire logic                                  rst_n,
    input  wire logic                                  scl_in,
    input  wire logic                                  sda_in,
    output logic                                       sda_out,
    output logic                                       sda_oe,
    input  wire logic                                  otp_load,
    input  wire logic [7:0]                            otp_override_a,
    input  wire logic [7:0]                            otp_override_b,
    input  wire logic [7:0]                            otp_fault_mask,
    input  wire logic [reor_pkg::NUM_RAILS-1:0]        rail_kill_n,
    input  wire logic [reor_pkg::NUM_RAILS-1:0]        seq_request_pin,
    input  wire logic [reor_pkg::NUM_GPO-1:0]          gpo_is_output,
    input  wire logic [reor_pkg::NUM_GPO-1:0]          gpo_push_pull,
    input  wire logic [reor_pkg::NUM_MASKED_RAILS-1:0] rail_fault,
    output logic      [reor_pkg::NUM_RAILS-1:0]        rail_enable,
    output logic                                       shutdown_req,
    output logic      [reor_pkg::NUM_GPO-1:0]          gpo_out,
    output logic      [reor_pkg::NUM_GPO-1:0]          gpo_oe
);

    logic [2:0]                             scl_sync_r;
    logic [2:0]                             sda_sync_r;
    logic [reor_pkg::NUM_RAILS-1:0]         req_meta_r;
    logic [reor_pkg::NUM_RAILS-1:0]         req_sync_r;
    logic                                   scl_rise;
    logic                                   scl_fall;
    logic                                   bus_start;
    logic                                   bus_stop;
    reor_pkg::reor_state_type               state_r;
    logic [3:0]                             bit_cnt_r;
    logic [7:0]                             shift_r;
    logic [7:0]                             rshift_r;
    logic [7:0]                             ptr_r;
    logic                                   rw_r;
    logic                                   nack_r;
    logic                                   wr_stb_r;
    logic [7:0]                             wr_data_r;
    logic [7:0]                             wr_addr_r;
    logic [7:0]                             override_a_r;
    logic [7:0]                             override_b_r;
    logic [7:0]                             fault_mask_r;
    logic [7:0]                             rd_data;
    logic [reor_pkg::NUM_RAILS-1:0]         force_on;
    logic [reor_pkg::NUM_GPO-1:0]           gpo_level;
    logic [reor_pkg::NUM_GPO-1:0]           gpo_is_pp;

    // ==========================================================
    // Pin synchronisers; bus pins use stages two and three, request pins two flops
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_sync_r <= 3'b111;
            sda_sync_r <= 3'b111;
            req_meta_r <= '0;
            req_sync_r <= '0;
            sda_out    <= 1'b0;
        end
        else
        begin
            scl_sync_r <= {scl_sync_r[1:0], scl_in};
            sda_sync_r <= {sda_sync_r[1:0], sda_in};
            req_meta_r <= seq_request_pin;
            req_sync_r <= req_meta_r;
            sda_out    <= 1'b0; // Open drain: the data line is only ever pulled low
        end
    end

    // Bus events from the settled samples
    assign scl_rise  = scl_sync_r[1] & ~scl_sync_r[2];
    assign scl_fall  = ~scl_sync_r[1] & scl_sync_r[2];
    assign bus_start = scl_sync_r[1] & scl_sync_r[2] & ~sda_sync_r[1] & sda_sync_r[2];
    assign bus_stop  = scl_sync_r[1] & scl_sync_r[2] & sda_sync_r[1] & ~sda_sync_r[2];

    // ==========================================================
    // Read mux; unmapped offsets read as zero
    always_comb
    begin
        case (ptr_r)
            reor_pkg::OFS_OVERRIDE_A: rd_data = override_a_r;
            reor_pkg::OFS_OVERRIDE_B: rd_data = override_b_r;
            reor_pkg::OFS_FAULT_MASK: rd_data = fault_mask_r;
            default:                  rd_data = reor_pkg::RST_READ_DATA;
        endcase
    end

    // ==========================================================
    // Serial target: address, register pointer, then data bytes
    // Pointer auto-increments so a burst can cover all three registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r   <= reor_pkg::ST_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r   <= 8'h00;
            rshift_r  <= 8'h00;
            ptr_r     <= 8'h00;
            rw_r      <= 1'b0;
            nack_r    <= 1'b0;
            sda_oe    <= 1'b0;
            wr_stb_r  <= 1'b0;
            wr_data_r <= 8'h00;
            wr_addr_r <= 8'h00;
        end
        else
        begin
            wr_stb_r <= 1'b0;
            if (bus_start || bus_stop) // A start opens a frame, a stop closes it
            begin
                state_r   <= bus_start ? reor_pkg::ST_ADDR : reor_pkg::ST_IDLE;
                bit_cnt_r <= 4'h0;
                sda_oe    <= 1'b0;
            end
            else if (scl_rise)
            begin
                // Data is sampled while the clock is high
                case (state_r)
                    reor_pkg::ST_ADDR, reor_pkg::ST_REG, reor_pkg::ST_WDATA:
                    begin
                        shift_r   <= {shift_r[6:0], sda_sync_r[1]};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end
                    reor_pkg::ST_RDATA: bit_cnt_r <= bit_cnt_r + 4'h1;
                    reor_pkg::ST_MACK:  nack_r <= sda_sync_r[1];
                    default:            nack_r <= nack_r;
                endcase
            end
            else if (scl_fall)
            begin
                // The line only changes while the clock is low
                case (state_r)
                    reor_pkg::ST_ADDR:
                        if (bit_cnt_r == reor_pkg::BITS_PER_BYTE)
                        begin
                            if (shift_r[7:1] == TARGET_ADDR)
                            begin
                                rw_r    <= shift_r[0];
                                sda_oe  <= 1'b1;
                                state_r <= reor_pkg::ST_AACK;
                            end
                            else
                                state_r <= reor_pkg::ST_IDLE;
                        end
                    reor_pkg::ST_AACK:
                    begin
                        bit_cnt_r <= 4'h0;
                        if (rw_r)
                        begin
                            rshift_r <= {rd_data[6:0], 1'b0};
                            sda_oe   <= ~rd_data[7];
                            ptr_r    <= ptr_r + 8'h01;
                            state_r  <= reor_pkg::ST_RDATA;
                        end
                        else
                        begin
                            sda_oe  <= 1'b0;
                            state_r <= reor_pkg::ST_REG;
                        end
                    end
                    reor_pkg::ST_REG:
                        if (bit_cnt_r == reor_pkg::BITS_PER_BYTE)
                        begin
                            ptr_r   <= shift_r;
                            sda_oe  <= 1'b1;
                            state_r <= reor_pkg::ST_RACKR;
                        end
                    reor_pkg::ST_WDATA:
                        if (bit_cnt_r == reor_pkg::BITS_PER_BYTE)
                        begin
                            wr_stb_r  <= 1'b1;
                            wr_addr_r <= ptr_r;
                            wr_data_r <= shift_r;
                            ptr_r     <= ptr_r + 8'h01;
                            sda_oe    <= 1'b1;
                            state_r   <= reor_pkg::ST_WACK;
                        end
                    reor_pkg::ST_RACKR, reor_pkg::ST_WACK:
                    begin
                        bit_cnt_r <= 4'h0;
                        sda_oe    <= 1'b0;
                        state_r   <= reor_pkg::ST_WDATA;
                    end
                    reor_pkg::ST_RDATA:
                        if (bit_cnt_r == reor_pkg::BITS_PER_BYTE)
                        begin
                            sda_oe  <= 1'b0;
                            state_r <= reor_pkg::ST_MACK;
                        end
                        else
                        begin
                            sda_oe   <= ~rshift_r[7];
                            rshift_r <= {rshift_r[6:0], 1'b0};
                        end
                    reor_pkg::ST_MACK:
                        if (nack_r)
                            state_r <= reor_pkg::ST_IDLE;
                        else
                        begin
                            bit_cnt_r <= 4'h0;
                            rshift_r  <= {rd_data[6:0], 1'b0};
                            sda_oe    <= ~rd_data[7];
                            ptr_r     <= ptr_r + 8'h01;
                            state_r   <= reor_pkg::ST_RDATA;
                        end
                    default: state_r <= reor_pkg::ST_IDLE;
                endcase
            end
        end
    end

    // ==========================================================
    // Register bank; factory load takes priority over a host write
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            override_a_r <= reor_pkg::RST_OVERRIDE_A;
            override_b_r <= reor_pkg::RST_OVERRIDE_B;
            fault_mask_r <= reor_pkg::RST_FAULT_MASK;
        end
        else if (otp_load)
        begin
            override_a_r <= otp_override_a;
            override_b_r <= otp_override_b;
            fault_mask_r <= otp_fault_mask;
        end
        else if (wr_stb_r) // Unmapped offsets swallow the write
            case (wr_addr_r)
                reor_pkg::OFS_OVERRIDE_A: override_a_r <= wr_data_r;
                reor_pkg::OFS_OVERRIDE_B: override_b_r <= wr_data_r;
                reor_pkg::OFS_FAULT_MASK: fault_mask_r <= wr_data_r;
                default:                  fault_mask_r <= fault_mask_r;
            endcase
    end

    // ==========================================================
    // Force vector in rail order and general-purpose output fields
    assign force_on  = {override_b_r[reor_pkg::OVB_FORCE_LSB +: reor_pkg::OVB_FORCE_W],
                        override_a_r};
    assign gpo_level = override_b_r[reor_pkg::OVB_LEVEL_LSB +: reor_pkg::NUM_GPO];
    // Output 4 can never drive high actively
    assign gpo_is_pp = gpo_push_pull & ~(4'b0001 << reor_pkg::GPO_OPEN_DRAIN_ONLY);

    // ==========================================================
    // General-purpose outputs; unconfigured pins float, so unused levels do nothing
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gpo_out <= '0;
            gpo_oe  <= '0;
        end
        else
        begin
            gpo_out <= gpo_level & gpo_is_pp & gpo_is_output;
            gpo_oe  <= gpo_is_output & (gpo_is_pp | ~gpo_level);
        end
    end

    // ==========================================================
    // Rail gating and shutdown
    reor_rail_gate u_rail_gate
    (
        .clk          (clk),
        .rst_n        (rst_n),
        .force_on     (force_on),
        .rail_kill_n  (rail_kill_n),
        .seq_request  (req_sync_r),
        .fault_ignore (fault_mask_r),
        .rail_fault   (rail_fault),
        .rail_enable  (rail_enable),
        .shutdown_req (shutdown_req)
    );
endmodule // reor_top

// *** tb/reor_top_monitor.sv ***
// Checker: port-level assertions of the rail override register block
`timescale 1ns/1ps

module reor_top_monitor
(
    input wire logic                                  clk,
    input wire logic                                  rst_n,
    input wire logic                                  scl_in,
    input wire logic                                  sda_out,
    input wire logic                                  sda_oe,
    input wire logic [reor_pkg::NUM_RAILS-1:0]        rail_kill_n,
    input wire logic [reor_pkg::NUM_RAILS-1:0]        seq_request_pin,
    input wire logic [reor_pkg::NUM_GPO-1:0]          gpo_is_output,
    input wire logic [reor_pkg::NUM_GPO-1:0]          gpo_push_pull,
    input wire logic [reor_pkg::NUM_MASKED_RAILS-1:0] rail_fault,
    input wire logic [reor_pkg::NUM_RAILS-1:0]        rail_enable,
    input wire logic                                  shutdown_req,
    input wire logic [reor_pkg::NUM_GPO-1:0]          gpo_out,
    input wire logic [reor_pkg::NUM_GPO-1:0]          gpo_oe
);
    // ==========
    // Set one edge after release, so $past never pairs reset outputs with live inputs
    logic up_r;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            up_r <= 1'b0;
        else
            up_r <= 1'b1;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ==========
    // Rail gating and fault shutdown
    kill_off_a: assert property ((rail_enable & ~$past(rail_kill_n)) == '0)
        else $error("rail on while its kill bit is zero");
    req_on_a: assert property ($stable(rail_kill_n & seq_request_pin) [*5]
        |-> (rail_kill_n & seq_request_pin & ~rail_enable) == '0)
        else $error("requested rail stays off");
    no_fault_a: assert property (rail_fault == '0 |=> !shutdown_req)
        else $error("shutdown without any fault");

    // ==========
    // Output pins and data line
    gpo_idle_a: assert property (((gpo_oe | gpo_out) & ~$past(gpo_is_output)) == '0)
        else $error("pin driven while not configured as output");
    od_high_a: assert property ((gpo_out & ~{1'b0, $past(gpo_push_pull[2:0])}) == '0)
        else $error("open-drain pin driven high");
    pp_drive_a: assert property (up_r
        |-> ($past(gpo_is_output & gpo_push_pull) & 4'h7 & ~gpo_oe) == '0)
        else $error("push-pull output not driven");
    sda_low_a: assert property (!sda_out)
        else $error("data line driven high");
    ack_edge_a: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data line changed while clock high");

    cover property ($rose(shutdown_req));
    cover property ($rose(sda_oe));
    cover property ($rose(rail_enable[0]));
endmodule // reor_top_monitor

bind reor_top reor_top_monitor u_monitor (.clk(clk), .rst_n(rst_n), .scl_in(scl_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .rail_kill_n(rail_kill_n),
    .seq_request_pin(seq_request_pin), .gpo_is_output(gpo_is_output),
    .gpo_push_pull(gpo_push_pull), .rail_fault(rail_fault), .rail_enable(rail_enable),
    .shutdown_req(shutdown_req), .gpo_out(gpo_out), .gpo_oe(gpo_oe));

// *** tb/reor_i2c_host.sv ***
// Partner: serial register host, clock and open-drain data pull
`timescale 1ns/1ps

module reor_i2c_host
(
    input  wire logic       clk,
    input  wire logic       sda_line,
    output logic            scl,
    output logic            sda_pull,
    output logic            rd_done,
    output logic [7:0]      rd_byte,
    output logic            ack_seen
);
    localparam int Q = 10; // Quarter bit in clocks, well above the 3-flop sync delay

    initial
    begin
        scl = 1'b1;
        sda_pull = 1'b0;
        rd_done = 1'b0;
        rd_byte = 8'h00;
        ack_seen = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    // One quarter bit; data moves while the clock is low, except in start and stop
    task automatic step(input logic c, input logic d);
        scl = c;
        sda_pull = d;
        tick(Q);
    endtask

    task automatic start();
        step(scl, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
    endtask

    task automatic stop();
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
        step(1'b1, 1'b0);
    endtask

    task automatic bit_out(input logic b);
        step(1'b0, !b);
        step(1'b1, !b);
        step(1'b1, !b);
        step(1'b0, !b);
    endtask

    // Sampled mid-high, long after the device has settled its answer
    task automatic bit_in(output logic b);
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        b = sda_line;
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
    endtask

    task automatic byte_out(input logic [7:0] d, output logic a);
        logic x;
        for (int i = 7; i >= 0; i--)
            bit_out(d[i]);
        bit_in(x);
        a = !x;
    endtask

    task automatic byte_in(input logic last, output logic [7:0] d);
        for (int i = 7; i >= 0; i--)
            bit_in(d[i]);
        bit_out(last);
    endtask

    // Three data bytes to consecutive offsets; refused address ends at once
    task automatic wr(input logic [6:0] adr, input logic [7:0] ofs, input logic [23:0] d);
        logic a;
        start();
        byte_out({adr, 1'b0}, ack_seen);
        if (ack_seen)
        begin
            byte_out(ofs, a);
            for (int i = 2; i >= 0; i--)
                byte_out(d[i*8 +: 8], a);
        end
        stop();
    endtask

    task automatic rd(input logic [6:0] adr, input logic [7:0] ofs, input int n);
        logic a;
        start();
        byte_out({adr, 1'b0}, ack_seen);
        if (ack_seen)
        begin
            byte_out(ofs, a);
            start();
            byte_out({adr, 1'b1}, a);
            for (int i = 0; i < n; i++)
            begin
                byte_in(i == n - 1, rd_byte);
                rd_done = 1'b1;
                tick(1);
                rd_done = 1'b0;
            end
        end
        stop();
    endtask
endmodule // reor_i2c_host

// *** tb/reor_top_tb.sv ***
// Testbench: register access, rail gating, output pins and fault masking
`timescale 1ns/1ps

module reor_top_tb;
    typedef struct { int k; logic [11:0] v; } reor_note_type;
    localparam logic [6:0] ADR = reor_pkg::TARGET_ADDR_DEFAULT;
    localparam string NAMES [5] = '{"read", "rail", "gpo", "shut", "ack"};

    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        otp_load = 1'b0;
    logic [7:0]  otp_override_a = 8'h00;
    logic [7:0]  otp_override_b = 8'h00;
    logic [7:0]  otp_fault_mask = 8'h00;
    logic [11:0] rail_kill_n = 12'h000;
    logic [11:0] seq_request_pin = 12'h000;
    logic [3:0]  gpo_is_output = 4'h0;
    logic [3:0]  gpo_push_pull = 4'h0;
    logic [7:0]  rail_fault = 8'h00;
    logic        sda_out, sda_oe, shutdown_req, scl, sda_pull, rd_done, ack_seen;
    logic [11:0] rail_enable, f, got;
    logic [3:0]  gpo_out, gpo_oe, pp;
    logic [7:0]  rd_byte, a, b, m;
    int          mismatches = 0;
    int          checked = 0;
    reor_note_type exp_q [$];
    reor_note_type note;
    event        snap;
    wire         sda_line = !(sda_pull || (sda_oe && !sda_out)); // Pull-up on the line

    always #2.5 clk = ~clk;

    reor_top DUT (.clk, .rst_n, .scl_in(scl), .sda_in(sda_line), .sda_out, .sda_oe,
        .otp_load, .otp_override_a, .otp_override_b, .otp_fault_mask, .rail_kill_n,
        .seq_request_pin, .gpo_is_output, .gpo_push_pull, .rail_fault, .rail_enable,
        .shutdown_req, .gpo_out, .gpo_oe);

    reor_i2c_host host (.clk, .sda_line, .scl, .sda_pull, .rd_done, .rd_byte, .ack_seen);

    task automatic final_report();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Note an expectation; pin results are sampled at once, reads when they arrive
    task automatic chk(input int k, input logic [11:0] v);
        exp_q.push_back('{k, v});
        if (k != 0)
        begin
            -> snap;
            @(negedge clk); // Keeps every later drive on the falling edge
        end
    endtask

    // Oldest note against whatever result just appeared
    always @(posedge rd_done or snap)
    begin
        note = exp_q.pop_front();
        case (note.k)
            0: got = {4'h0, rd_byte};
            1: got = rail_enable;
            2: got = {4'h0, gpo_oe, gpo_out};
            3: got = {11'h000, shutdown_req};
            default: got = {11'h000, ack_seen};
        endcase
        checked++;
        if (got !== note.v)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", NAMES[note.k], note.v, got);
        end
    end

    // Generous bound: the sequence needs about 39k clocks
    initial
    begin
        #400_000;
        mismatches++;
        final_report();
    end

    initial
    begin
        void'($urandom(32'hd854_6af2));
        {otp_override_a, otp_override_b, otp_fault_mask} = 24'($urandom);
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        otp_load = 1'b1;
        @(negedge clk);
        otp_load = 1'b0;
        host.tick(4);
        // Foreign address is refused, so nothing may change
        host.wr(ADR ^ 7'h01, reor_pkg::OFS_OVERRIDE_A, 24'hff_ffff);
        chk(4, 12'h000);
        chk(0, {4'h0, otp_override_a});
        chk(0, {4'h0, otp_override_b});
        chk(0, {4'h0, otp_fault_mask});
        host.rd(ADR, reor_pkg::OFS_OVERRIDE_A, 3);
        for (int i = 0; i < 8; i++)
        begin
            {a, b, m} = 24'($urandom);
            {rail_kill_n, seq_request_pin} = 24'($urandom);
            {gpo_is_output, gpo_push_pull, rail_fault} = 16'($urandom);
            if (i == 0)
                {m, rail_fault} = 16'hffff;
            if (i == 1)
                {a, b[3:0], seq_request_pin} = 24'hff_f000;
            host.wr(ADR, reor_pkg::OFS_OVERRIDE_A, {a, b, m});
            chk(4, 12'h001);
            host.tick(10);
            f = {b[3:0], a};
            pp = gpo_push_pull & 4'h7;
            chk(1, rail_kill_n & (f | seq_request_pin));
            chk(2, {4'h0, gpo_is_output & (pp | ~b[7:4]), b[7:4] & pp & gpo_is_output});
            chk(3, {11'h000, |(rail_fault & ~m)});
            chk(0, {4'h0, a});
            chk(0, {4'h0, b});
            chk(0, {4'h0, m});
            chk(0, 12'h000);
            host.rd(ADR, reor_pkg::OFS_OVERRIDE_A, 4);
        end
        final_report();
    end
endmodule // reor_top_tb
